// >>> csa_cfg.svh
// register map, field positions and reset values of the scan block
`ifndef CSA_CFG_SVH
`define CSA_CFG_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define CSA_OFS_CONFIG     8'h00
`define CSA_OFS_CONTROL    8'h04
`define CSA_OFS_MUX        8'h08
`define CSA_OFS_SCAN_START 8'h0C
`define CSA_OFS_SCAN_END   8'h10
`define CSA_OFS_IRQ_EN_TWO 8'h14
`define CSA_OFS_STATUS     8'h18
`define CSA_OFS_MASK       8'h1C
`define CSA_OFS_ANALOG     8'h20

// ************************************************************
// field positions
// ************************************************************
`define CSA_CFG_SRC_LSB    4
`define CSA_CFG_SRC_MSB    6
`define CSA_CFG_ACC_LSB    0
`define CSA_CFG_ACC_MSB    1
`define CSA_CTL_BUSY       0
`define CSA_IEN_DONE       0
`define CSA_ST_DONE        0
`define CSA_ST_GT          1

// ************************************************************
// reset values
// ************************************************************
`define CSA_RST_CONFIG     8'h00
`define CSA_RST_STATUS     2'h0
`define CSA_RST_MASK       2'h0

`endif

// >>> csa_pkg.sv
// types shared by the scan control block
`default_nettype none
package csa_pkg;
  // gray codes along idle -> convert -> step
  typedef enum logic [1:0]
  {
    CSA_IDLE = 2'b00,
    CSA_CONV = 2'b01,
    CSA_STEP = 2'b11
  } csa_state_e;

  typedef enum logic [2:0]
  {
    CSA_SRC_BUSY  = 3'h0,
    CSA_SRC_TMR0  = 3'h1,
    CSA_SRC_TMR2  = 3'h2,
    CSA_SRC_TMR1  = 3'h3,
    CSA_SRC_CONT  = 3'h4,
    CSA_SRC_CONT5 = 3'h5,
    CSA_SRC_CONT6 = 3'h6,
    CSA_SRC_SCAN  = 3'h7
  } csa_src_e;
endpackage
`default_nettype wire

// >>> csa_scan_ctrl.sv
// start-source selection, accumulation, auto-scan and bus slave
//
// Notes on behaviour
// - three-bit field picks conversion start source
// - continuous modes wait for busy bit set
// - done interrupt only with enable bit set
// - complete flagged after last accumulated conversion; the code sets the done status bit only while the enable bit is set
// - code all ones enables auto-scan
// - scan-start write copies into mux select
// - busy write one starts auto-scan
// - after accumulation step to next analog pin
// - stepping continues until mux equals end
// - after end channel reload start channel
// - each selected channel converted regardless
// - auto-scan keeps running in suspend
// - greater-than event in suspend wakes device
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`include "csa_cfg.svh"
`default_nettype none
module csa_scan_ctrl #(
  parameter int NCH = 16
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // timer overflows, one-cycle pulses on hclk
  input  wire logic        tmr0_ovf,
  input  wire logic        tmr1_ovf,
  input  wire logic        tmr2_ovf,
  // measurement front end
  output logic             conv_start,
  output logic [3:0]       channel_mux_select,
  input  wire logic        conv_done,
  input  wire logic        gt_event,
  // power management
  input  wire logic        suspend_mode,
  output logic             wake_req,
  // interrupt
  output logic             irq
);
  import csa_pkg::*;

  initial
  begin
    if (NCH < 2 || NCH > 16)
      $error("NCH must lie in 2..16");
  end

  // ************************************************************
  // helper functions
  // ************************************************************
  function automatic logic [3:0] acc_last(input logic [1:0] code);
    // index of the last conversion of an accumulation: 0,3,7,15 for 1,4,8,16
    unique case (code)
      2'h0: acc_last = 4'h0;
      2'h1: acc_last = 4'h3;
      2'h2: acc_last = 4'h7;
      2'h3: acc_last = 4'hF;
    endcase
  endfunction

  // next analog channel above cur, stopping at the end channel
  function automatic logic [3:0] next_chan(input logic [3:0]  cur,
                                           input logic [3:0]  fin,
                                           input logic [3:0]  first,
                                           input logic [15:0] ana);
    logic       found;
    logic [3:0] res;
    found = 1'b0;
    res   = first;
    for (int i = 0; i < NCH; i++)
    begin
      if (!found && i > cur && (ana[i] || i == fin))
      begin
        found = 1'b1;
        res   = i[3:0];
      end
    end
    next_chan = res;
  endfunction

  // ************************************************************
  // bus address phase capture
  // ************************************************************
  logic       dp_wr_reg;
  logic       dp_rd_reg;
  logic [7:0] dp_addr_reg;

  wire logic ap_valid = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_reg   <= 1'b0;
      dp_rd_reg   <= 1'b0;
      dp_addr_reg <= 8'h00;
    end
    else
    begin
      dp_wr_reg   <= ap_valid && hwrite;
      dp_rd_reg   <= ap_valid && !hwrite;
      dp_addr_reg <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire logic wr_config  = dp_wr_reg && dp_addr_reg == `CSA_OFS_CONFIG;
  wire logic wr_control = dp_wr_reg && dp_addr_reg == `CSA_OFS_CONTROL;
  wire logic wr_mux     = dp_wr_reg && dp_addr_reg == `CSA_OFS_MUX;
  wire logic wr_sstart  = dp_wr_reg && dp_addr_reg == `CSA_OFS_SCAN_START;
  wire logic wr_send    = dp_wr_reg && dp_addr_reg == `CSA_OFS_SCAN_END;
  wire logic wr_ien     = dp_wr_reg && dp_addr_reg == `CSA_OFS_IRQ_EN_TWO;
  wire logic wr_mask    = dp_wr_reg && dp_addr_reg == `CSA_OFS_MASK;
  wire logic wr_analog  = dp_wr_reg && dp_addr_reg == `CSA_OFS_ANALOG;
  wire logic rd_status  = dp_rd_reg && dp_addr_reg == `CSA_OFS_STATUS;

  // ************************************************************
  // software registers
  // ************************************************************
  logic [7:0]  config_reg;
  logic [3:0]  sstart_reg;
  logic [3:0]  send_reg;
  logic        ien_reg;
  logic [1:0]  mask_reg;
  logic [15:0] analog_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      config_reg <= `CSA_RST_CONFIG;
      sstart_reg <= 4'h0;
      send_reg   <= 4'h0;
      ien_reg    <= 1'b0;
      mask_reg   <= `CSA_RST_MASK;
      analog_reg <= 16'h0000;
    end
    else
    begin
      if (wr_config)
        config_reg <= hwdata[7:0];
      if (wr_sstart)
        sstart_reg <= hwdata[3:0];
      if (wr_send)
        send_reg <= hwdata[3:0];
      if (wr_ien)
        ien_reg <= hwdata[`CSA_IEN_DONE];
      if (wr_mask)
        mask_reg <= hwdata[1:0];
      if (wr_analog)
        analog_reg <= hwdata[15:0];
    end
  end

  // ************************************************************
  // mode decode
  // ************************************************************
  csa_src_e  src;
  assign src = csa_src_e'(config_reg[`CSA_CFG_SRC_MSB:`CSA_CFG_SRC_LSB]);

  wire logic       scan_on  = src == CSA_SRC_SCAN;
  wire logic       cont_on  = src[2];
  wire logic [3:0] acc_end  =
    acc_last(config_reg[`CSA_CFG_ACC_MSB:`CSA_CFG_ACC_LSB]);
  wire logic       tmr_hit  =
    (src == CSA_SRC_TMR0 && tmr0_ovf) ||
    (src == CSA_SRC_TMR2 && tmr2_ovf) ||
    (src == CSA_SRC_TMR1 && tmr1_ovf);
  wire logic       busy_set = wr_control && hwdata[`CSA_CTL_BUSY];
  wire logic       busy_clr = wr_control && !hwdata[`CSA_CTL_BUSY];

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  csa_state_e state_reg;
  csa_state_e state_next;
  logic       busy_reg;
  logic [3:0] acc_cnt_reg;
  logic [3:0] mux_reg;
  logic       start_reg;

  wire logic idle_go = state_reg == CSA_IDLE &&
    (tmr_hit || ((src == CSA_SRC_BUSY || cont_on) && (busy_reg || busy_set)));
  wire logic start_now = idle_go || state_reg == CSA_STEP;
  wire logic conv_fin  = state_reg == CSA_CONV && conv_done;
  wire logic done_evt  = conv_fin && acc_cnt_reg == acc_end;
  // a cleared busy bit ends continuous running after the accumulation
  wire logic keep_run  = cont_on && busy_reg && !busy_clr;
  wire logic at_end    = mux_reg == send_reg;
  wire logic [3:0] mux_step = at_end ? sstart_reg :
    next_chan(mux_reg, send_reg, sstart_reg, analog_reg);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      CSA_IDLE:
        if (start_now)
          state_next = CSA_CONV;
      CSA_CONV:
        if (conv_fin)
          state_next = (!done_evt || keep_run) ? CSA_STEP : CSA_IDLE;
      CSA_STEP:
        state_next = CSA_CONV;
      default:
        state_next = CSA_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg   <= CSA_IDLE;
      acc_cnt_reg <= 4'h0;
      start_reg   <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      start_reg   <= start_now;
      if (done_evt || state_reg == CSA_IDLE)
        acc_cnt_reg <= 4'h0;
      else if (conv_fin)
        acc_cnt_reg <= acc_cnt_reg + 4'h1;
    end
  end

  // hardware clear loses against a set in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      busy_reg <= 1'b0;
    else if (busy_set || tmr_hit && state_reg == CSA_IDLE)
      busy_reg <= 1'b1;
    else if (busy_clr || (done_evt && !cont_on))
      busy_reg <= 1'b0;
  end

  // scanner stepping beats software writes to the mux
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mux_reg <= 4'h0;
    else if (done_evt && scan_on && keep_run)
      mux_reg <= mux_step;
    else if (wr_sstart && scan_on)
      mux_reg <= hwdata[3:0];
    else if (wr_mux)
      mux_reg <= hwdata[3:0];
  end

  assign conv_start         = start_reg;
  assign channel_mux_select = mux_reg;

  // ************************************************************
  // wake, status and interrupt
  // ************************************************************
  // no clock gating here, so the scan simply keeps going in suspend
  wire logic in_seq  = mux_reg >= sstart_reg && mux_reg <= send_reg;
  wire logic wake_ev = suspend_mode && scan_on && gt_event &&
    in_seq && state_reg != CSA_IDLE;
  logic       wake_reg;
  logic [1:0] status_reg;

  wire logic [1:0] st_set = {wake_ev || (gt_event && scan_on),
                             done_evt && ien_reg};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_reg   <= 1'b0;
      status_reg <= `CSA_RST_STATUS;
    end
    else
    begin
      wake_reg   <= wake_ev;
      status_reg <= (rd_status ? 2'h0 : status_reg) | st_set;
    end
  end

  assign wake_req = wake_reg;
  assign irq      = |(status_reg & mask_reg);

  // ************************************************************
  // read data
  // ************************************************************
  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (dp_addr_reg)
      `CSA_OFS_CONFIG:     rd_mux = {24'h0, config_reg};
      `CSA_OFS_CONTROL:    rd_mux = {31'h0, busy_reg};
      `CSA_OFS_MUX:        rd_mux = {28'h0, mux_reg};
      `CSA_OFS_SCAN_START: rd_mux = {28'h0, sstart_reg};
      `CSA_OFS_SCAN_END:   rd_mux = {28'h0, send_reg};
      `CSA_OFS_IRQ_EN_TWO: rd_mux = {31'h0, ien_reg};
      `CSA_OFS_STATUS:     rd_mux = {30'h0, status_reg};
      `CSA_OFS_MASK:       rd_mux = {30'h0, mask_reg};
      `CSA_OFS_ANALOG:     rd_mux = {16'h0, analog_reg};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end
  assign hrdata = dp_rd_reg ? rd_mux : 32'h0000_0000;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_timer_start: assert property (
    (state_reg == CSA_IDLE && tmr_hit) |=> conv_start && busy_reg)
    else $error("timer overflow did not start a conversion");

  a_cont_waits_busy: assert property (
    (state_reg == CSA_IDLE && cont_on && !busy_reg && !busy_set)
      |=> !conv_start)
    else $error("continuous mode started without busy");

  a_irq_enable: assert property (
    $rose(status_reg[`CSA_ST_DONE]) |-> $past(ien_reg) && $past(done_evt))
    else $error("done status set without enable");

  a_last_conv: assert property (
    $rose(status_reg[`CSA_ST_DONE])
      |-> $past(acc_cnt_reg) == $past(acc_end) && $past(conv_done))
    else $error("complete flagged before last conversion");

  a_scan_copy: assert property (
    (wr_sstart && scan_on && !done_evt) |=> mux_reg == $past(hwdata[3:0]))
    else $error("scan start not copied to mux");

  a_scan_wrap: assert property (
    (done_evt && scan_on && keep_run && at_end)
      |=> mux_reg == $past(sstart_reg) ##1 conv_start)
    else $error("scan did not wrap to start channel");

  a_step_restart: assert property (
    (conv_fin && state_next == CSA_STEP) |=> ##1 conv_start ##1 !conv_start)
    else $error("no restart after conversion");

  a_busy_clear: assert property (
    (done_evt && !cont_on && !busy_set)
      |=> !busy_reg ##1 (!conv_start || $past(tmr_hit || busy_set)))
    else $error("single shot busy not cleared");

  a_wake_cause: assert property (
    wake_req |-> $past(suspend_mode) && $past(gt_event) && $past(scan_on))
    else $error("wake without suspended compare event");

  c_scan_wrap: cover property (done_evt && scan_on && at_end && keep_run);
  c_wake:      cover property (wake_req);
  c_timer:     cover property (state_reg == CSA_IDLE && tmr_hit);
  c_irq:       cover property ($rose(irq));

endmodule
`default_nettype wire

// >>> csa_fe_model.sv
// behavioural model of the measurement front end behind the scan block
`default_nettype none
module csa_fe_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // front end link
  input  wire logic       conv_start,
  output logic            conv_done,
  output logic            gt_event,
  // behaviour set by the bench
  input  wire logic [3:0] lat,
  input  wire logic       touch
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // lat must stay nonzero, or a start would never be answered
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt       <= 4'h0;
      conv_done <= 1'b0;
      gt_event  <= 1'b0;
    end
    else
    begin
      conv_done <= (cnt == 4'h1);
      gt_event  <= (cnt == 4'h1) && touch;
      if (conv_start)
        cnt <= lat;
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
endmodule
`default_nettype wire

// >>> csa_scan_ctrl_tb.sv
// self-checking bench for the scan control block
`include "csa_cfg.svh"
`default_nettype none
module csa_scan_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csa_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, tv;
  logic        conv_start, conv_done, gt_event, suspend_mode, wake_req;
  logic        irq, touch, ie;
  logic [3:0]  mux, lat, e;
  logic [3:0]  chq[$];
  int          bad_count, check_count, starts, n, s, c, seed;
  assign hready = hreadyout;
  csa_scan_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .tmr0_ovf(tv[0]), .tmr1_ovf(tv[1]),
    .tmr2_ovf(tv[2]), .conv_start(conv_start),
    .channel_mux_select(mux), .conv_done(conv_done),
    .gt_event(gt_event), .suspend_mode(suspend_mode),
    .wake_req(wake_req), .irq(irq));
  csa_fe_model fe (.hclk(hclk), .hresetn(hresetn),
    .conv_start(conv_start), .conv_done(conv_done),
    .gt_event(gt_event), .lat(lat), .touch(touch));
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // one entry per start, with the channel it was taken on
  always @(posedge hclk)
    if (conv_start === 1'b1)
    begin
      starts++;
      chq.push_back(mux);
    end
  function automatic int acc_n(input logic [1:0] k);
    return (k == 2'h0) ? 1 : (k == 2'h1) ? 4 : (k == 2'h2) ? 8 : 16;
  endfunction
  function automatic logic [3:0] nxt(input logic [3:0] cur, st, en,
                                     input logic [15:0] m);
    if (cur == en)
      return st;
    for (int i = cur + 1; i <= en; i++)
      if (i == en || m[i])
        return i[3:0];
    return st;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // which 0 waits for n starts, which 1 for a wake pulse
  task automatic wait_cond(input int which, input int lim);
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while ((which ? wake_req !== 1'b1 : starts < n) && k < lim);
    if (k >= lim)
    begin
      bad_count++;
      $display("mismatch wait %0d expected done seen timeout", which);
      final_report();
    end
  endtask
  // address phase held until hready, then data phase held until hready
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hready !== 1'b1 && k < 20);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hready !== 1'b1 && k < 40);
    rd = hrdata;
    if (hready !== 1'b1)
    begin
      bad_count++;
      $display("mismatch hready expected 1 seen timeout");
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdck(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tv = 3'h0;
    suspend_mode = 1'b0;
    touch = 1'b0;
    lat = 4'h1;
    seed = $urandom(93);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdck("config", `CSA_OFS_CONFIG, 32'h0);
    rdck("status", `CSA_OFS_STATUS, 32'h0);
    rdck("unmapped", 8'h40, 32'h0);
    $display("test reset done");
    // single shot on a busy write, every accumulation count
    for (int i = 0; i < 5; i++)
    begin
      s = (i < 4) ? i : $urandom_range(3);
      ie = (i < 4);
      lat <= 4'($urandom_range(4, 1));
      wr(`CSA_OFS_CONFIG, s);
      wr(`CSA_OFS_IRQ_EN_TWO, {31'h0, ie});
      wr(`CSA_OFS_MASK, 32'h1);
      starts = 0;
      wr(`CSA_OFS_CONTROL, 32'h1);
      n = acc_n(s[1:0]);
      wait_cond(0, 400);
      check("irq early", irq, 1'b0);
      repeat (8) @(posedge hclk);
      check("starts", starts, n);
      check("irq", irq, ie);
      rdck("busy", `CSA_OFS_CONTROL, 32'h0);
      rdck("status", `CSA_OFS_STATUS, {31'h0, ie});
      // the read clears status at the edge that ends its data phase
      @(posedge hclk);
      check("irq clear", irq, 1'b0);
    end
    $display("test busy start done");
    // timer sources: only the selected overflow starts a conversion
    for (c = 1; c < 4; c++)
    begin
      wr(`CSA_OFS_CONFIG, c << 4);
      s = (c == 1) ? 0 : (c == 2) ? 2 : 1;
      starts = 0;
      tv <= ~(3'h1 << s);
      @(posedge hclk);
      tv <= 3'h0;
      repeat (6) @(posedge hclk);
      check("wrong timer", starts, 0);
      tv <= 3'h1 << s;
      @(posedge hclk);
      tv <= 3'h0;
      repeat (10) @(posedge hclk);
      check("timer start", starts, 1);
    end
    $display("test timers done");
    // continuous single channel waits for the busy bit
    wr(`CSA_OFS_CONFIG, $urandom_range(6, 4) << 4);
    starts = 0;
    repeat (20) @(posedge hclk);
    check("no busy", starts, 0);
    wr(`CSA_OFS_CONTROL, 32'h1);
    n = 5;
    wait_cond(0, 200);
    wr(`CSA_OFS_CONTROL, 32'h0);
    repeat (20) @(posedge hclk);
    s = starts;
    repeat (20) @(posedge hclk);
    check("stopped", starts, s);
    $display("test continuous done");
    // auto-scan from a non-analog start channel
    wr(`CSA_OFS_ANALOG, 32'h30);
    wr(`CSA_OFS_SCAN_END, 32'h5);
    wr(`CSA_OFS_CONFIG, 32'h70);
    wr(`CSA_OFS_SCAN_START, 32'h2);
    rdck("mux copy", `CSA_OFS_MUX, 32'h2);
    chq.delete();
    starts = 0;
    wr(`CSA_OFS_CONTROL, 32'h1);
    n = 8;
    wait_cond(0, 400);
    e = 4'h2;
    for (int j = 0; j < 8; j++)
    begin
      check("scan channel", chq[j], e);
      e = nxt(e, 4'h2, 4'h5, 16'h0030);
    end
    $display("test auto-scan done");
    // scan keeps running in suspend and a touch wakes the device
    suspend_mode <= 1'b1;
    touch <= 1'b1;
    wait_cond(1, 300);
    // the wake may come from a conversion already under way
    starts = 0;
    repeat (20) @(posedge hclk);
    check("suspend scan", starts != 0, 1'b1);
    rdck("gt status", `CSA_OFS_STATUS, 32'h2);
    suspend_mode <= 1'b0;
    touch <= 1'b0;
    $display("test suspend done");
    final_report();
  end
endmodule
`default_nettype wire
